// file: logic/sfd_loader.sv
// spi flash directory loader: probe, directory read, boot decision and port sharing
`timescale 1ns/1ns
`default_nettype none
module sfd_loader
  import sfd_pkg::*;
(
  // system
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  // link-side clock for the jtag pass-through
  input  wire logic       jtagClk,
  input  wire logic       jtagRst_n,
  input  wire logic [7:0] jtagInstr,
  input  wire logic       jtagSck,
  input  wire logic       jtagCs_n,
  input  wire logic       jtagMosi,
  // pins
  input  wire logic       spiPortEn,
  input  wire logic       spiMasterMode,
  input  wire logic       spiMiso,
  output logic            spiSck,
  output logic            spiCs_n,
  output logic            spiMosi,
  output logic            spiOe,
  // fabric master
  input  wire logic       fabSck,
  input  wire logic       fabCs_n,
  input  wire logic       fabMosi,
  output logic            fabMiso,
  output logic            fabOwns,
  // control and status
  input  wire logic       powerUp,
  input  wire logic       brownout,
  input  wire logic       serviceReq,
  input  wire logic       iapReq,
  input  wire logic       zeroizeDone,
  output logic            addr4Byte,
  output logic            recoverySel,
  output logic            autoUpdateSel,
  output logic            bootStart,
  output logic [31:0]     imageAddr,
  output logic [7:0]      statusCode,
  output logic            statusValid,
  output logic            zeroCertReady
);

  // jtag domain: decode pass-through level, cross it as a level
  logic passJ_reg, passJ_next;
  always_comb passJ_next = (jtagInstr == JTAG_PASS_INSTR);
  always_ff @(posedge jtagClk) begin
    if (!jtagRst_n) passJ_reg <= 1'b0;
    else passJ_reg <= passJ_next;
  end

  // synchronisers for pins and the jtag level
  logic [1:0] syncEn_reg, syncMiso_reg, syncPass_reg, syncMode_reg;
  logic [3:0] sync_next;
  always_comb sync_next = {syncEn_reg[0], syncMiso_reg[0], syncPass_reg[0], syncMode_reg[0]};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncEn_reg   <= 2'h0;
      syncMiso_reg <= 2'h0;
      syncPass_reg <= 2'h0;
      syncMode_reg <= 2'h0;
    end else if (clkEn) begin
      syncEn_reg   <= {sync_next[3], spiPortEn};
      syncMiso_reg <= {sync_next[2], spiMiso};
      syncPass_reg <= {sync_next[1], passJ_reg};
      syncMode_reg <= {sync_next[0], spiMasterMode};
    end
  end
  logic portEn, misoS, passOn, isMaster;
  assign portEn   = syncEn_reg[1];
  assign misoS    = syncMiso_reg[1];
  assign passOn   = syncPass_reg[1];
  assign isMaster = syncMode_reg[1];

  // controller state
  sfd_state_t state_reg, state_next;
  sfd_owner_t owner_reg, owner_next;
  logic [6:0]  bitCnt_reg, bitCnt_next;
  logic [5:0]  div_reg, div_next;
  logic        sck_reg, sck_next;
  logic        cs_reg, cs_next;
  logic [95:0] tx_reg, tx_next;
  logic [63:0] rx_reg, rx_next;
  logic        a4_reg, a4_next;
  logic        rec_reg, rec_next;
  logic        auto_reg, auto_next;
  logic        boot_reg, boot_next;
  logic [31:0] img_reg, img_next;
  logic [7:0]  stat_reg, stat_next;
  logic        statV_reg, statV_next;
  logic        cert_reg, cert_next;
  logic [6:0]  len;
  logic        shiftDone, fall;
  logic [31:0] slot0, slot1;

  assign len       = (state_reg == ST_PROBE) ? BITS_HDR : BITS_RD3;
  assign fall      = (div_reg == SCK_DIV) && sck_reg;
  assign shiftDone = fall && (bitCnt_reg == len - 7'h01);
  // little-endian entries; 3-byte mode keeps only three bytes
  assign slot0 = a4_reg ? {rx_reg[39:32], rx_reg[47:40], rx_reg[55:48], rx_reg[63:56]}
                        : {8'h00, rx_reg[47:40], rx_reg[55:48], rx_reg[63:56]};
  assign slot1 = a4_reg ? {rx_reg[7:0], rx_reg[15:8], rx_reg[23:16], rx_reg[31:24]}
                        : (rx_reg[31:8] == 24'hffffff ? EMPTY_SLOT
                                                      : {8'h00, rx_reg[15:8], rx_reg[23:16], rx_reg[31:24]});

  always_comb begin
    state_next = state_reg;
    owner_next = owner_reg;
    bitCnt_next = bitCnt_reg;
    div_next   = div_reg;
    sck_next   = sck_reg;
    cs_next    = cs_reg;
    tx_next    = tx_reg;
    rx_next    = rx_reg;
    a4_next    = a4_reg;
    rec_next   = rec_reg;
    auto_next  = auto_reg;
    boot_next  = 1'b0;
    img_next   = img_reg;
    stat_next  = stat_reg;
    statV_next = 1'b0;
    cert_next  = cert_reg | zeroizeDone;
    if (passOn) owner_next = OWN_JTAG;
    else if (owner_reg == OWN_JTAG) owner_next = OWN_CTRL;
    if (iapReq && !isMaster) begin
      stat_next  = STATUS_NOT_MSTR;
      statV_next = 1'b1;
    end
    // shifter: mode 0, shift on falling edge, sample on rising
    if (state_reg == ST_PROBE || state_reg == ST_DIR) begin
      div_next = (div_reg == SCK_DIV) ? 6'h00 : div_reg + 6'h01;
      if (div_reg == SCK_DIV) begin
        sck_next = ~sck_reg;
        if (!sck_reg) rx_next = {rx_reg[62:0], misoS};
        else begin
          tx_next = {tx_reg[94:0], 1'b0};
          bitCnt_next = bitCnt_reg + 7'h01;
        end
      end
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (portEn && isMaster && (powerUp || brownout || serviceReq || iapReq) && !passOn) begin
          owner_next = OWN_CTRL;
          cs_next = 1'b0;
          bitCnt_next = 7'h00;
          div_next = 6'h00;
          sck_next = 1'b0;
          tx_next = {CMD_DISCOVERY, 24'h000000, 64'h0};
          state_next = ST_PROBE;
        end
      end
      ST_PROBE: if (shiftDone) begin
        // signature present means discovery supported; else fall back to 3-byte
        // first byte arrives first, so the word is compared byte-reversed
        a4_next = (rx_reg[31:0] == {SFDP_SIG_WORD[7:0], SFDP_SIG_WORD[15:8],
                                    SFDP_SIG_WORD[23:16], SFDP_SIG_WORD[31:24]});
        // a new command needs a deselect first, else the flash reads it as data
        cs_next = 1'b1;
        bitCnt_next = 7'h00;
        div_next = 6'h00;
        sck_next = 1'b0;
        tx_next = {CMD_FAST_READ, 24'h000000, 64'h0};
        state_next = ST_BUSY;
      end
      ST_DIR: if (shiftDone) begin
        cs_next = 1'b1;
        state_next = ST_DECIDE;
      end
      ST_DECIDE: begin
        if (slot1 == EMPTY_SLOT) begin
          rec_next = 1'b1;
          auto_next = 1'b0;
          img_next = slot0;
        end else begin
          rec_next = 1'b0;
          auto_next = 1'b1;
          img_next = slot1;
        end
        // the slot0 image must sit above the directory and inside reach
        if (slot0 == EMPTY_SLOT || slot0 < DIR_SIZE_BYTES || (!a4_reg && slot0 > LIMIT_3BYTE)) begin
          stat_next  = STATUS_NO_IMAGE;
          statV_next = 1'b1;
        end else boot_next = 1'b1;
        owner_next = OWN_FABRIC;
        state_next = ST_FABRIC;
      end
      ST_FABRIC: begin
        if (brownout || serviceReq) begin
          owner_next = OWN_CTRL;
          state_next = ST_IDLE;
        end
      end
      ST_BUSY: begin
        // one cycle deselected between probe and directory frames
        cs_next = 1'b0;
        state_next = ST_DIR;
      end
      default: state_next = ST_IDLE;
    endcase
    if (!portEn) begin
      cs_next = 1'b1;
      if (state_reg == ST_PROBE || state_reg == ST_DIR || state_reg == ST_BUSY) state_next = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      owner_reg <= OWN_CTRL;
      bitCnt_reg <= 7'h00;
      div_reg   <= 6'h00;
      sck_reg   <= 1'b0;
      cs_reg    <= 1'b1;
      tx_reg    <= 96'h0;
      rx_reg    <= 64'h0;
      a4_reg    <= 1'b0;
      rec_reg   <= 1'b0;
      auto_reg  <= 1'b0;
      boot_reg  <= 1'b0;
      img_reg   <= 32'h0;
      stat_reg  <= STATUS_OK;
      statV_reg <= 1'b0;
      cert_reg  <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      owner_reg <= owner_next;
      bitCnt_reg <= bitCnt_next;
      div_reg   <= div_next;
      sck_reg   <= sck_next;
      cs_reg    <= cs_next;
      tx_reg    <= tx_next;
      rx_reg    <= rx_next;
      a4_reg    <= a4_next;
      rec_reg   <= rec_next;
      auto_reg  <= auto_next;
      boot_reg  <= boot_next;
      img_reg   <= img_next;
      stat_reg  <= stat_next;
      statV_reg <= statV_next;
      cert_reg  <= cert_next;
    end
  end

  // port mux; jtag pins pass combinationally to keep its clock timing
  always_comb begin
    spiOe = portEn && isMaster;
    unique case (owner_reg)
      OWN_JTAG: begin spiSck = jtagSck; spiCs_n = jtagCs_n; spiMosi = jtagMosi; end
      OWN_FABRIC: begin spiSck = fabSck; spiCs_n = fabCs_n; spiMosi = fabMosi; end
      default: begin spiSck = sck_reg; spiCs_n = cs_reg; spiMosi = tx_reg[95]; end
    endcase
  end
  assign fabMiso       = spiMiso;
  assign fabOwns       = (owner_reg == OWN_FABRIC);
  assign addr4Byte     = a4_reg;
  assign recoverySel   = rec_reg;
  assign autoUpdateSel = auto_reg;
  assign bootStart     = boot_reg;
  assign imageAddr     = img_reg;
  assign statusCode    = stat_reg;
  assign statusValid   = statV_reg;
  assign zeroCertReady = cert_reg;
endmodule
`default_nettype wire

// file: logic/sfd_pkg.sv
// constants and types for the spi flash image directory loader
package sfd_pkg;
  localparam logic [7:0]  CMD_DISCOVERY   = 8'h5a;
  localparam logic [7:0]  CMD_FAST_READ   = 8'h0b;
  localparam logic [7:0]  JTAG_PASS_INSTR = 8'hb0;
  localparam logic [7:0]  SFDP_SIG0       = 8'h53;
  localparam logic [31:0] SFDP_SIG_WORD   = 32'h50444653;
  localparam logic [31:0] LIMIT_3BYTE     = 32'h00ffffff;  // 128 Mb = 16 MB
  localparam logic [31:0] DIR_SIZE_BYTES  = 32'h00000400;
  localparam logic [31:0] EMPTY_SLOT      = 32'hffffffff;
  localparam logic [7:0]  STATUS_OK       = 8'h00;
  localparam logic [7:0]  STATUS_NOT_MSTR = 8'h15;  // 21
  localparam logic [7:0]  STATUS_NO_IMAGE = 8'h16;  // 22
  localparam logic [5:0]  SCK_DIV         = 6'h02;
  localparam logic [6:0]  BITS_CMD_SFDP   = 7'h28;  // bits ahead of the first data bit
  localparam logic [6:0]  BITS_HDR        = 7'h48;  // 8 cmd 24 addr 8 dummy 32 data
  localparam logic [6:0]  BITS_RD3        = 7'h68;  // 8 cmd 24 addr 8 dummy 64 data
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_PROBE   = 4'h1,
    ST_DIR     = 4'h2,
    ST_DECIDE  = 4'h3,
    ST_FABRIC  = 4'h4,
    ST_BUSY    = 4'h5
  } sfd_state_t;
  typedef enum logic [1:0] {
    OWN_CTRL   = 2'h0,
    OWN_FABRIC = 2'h1,
    OWN_JTAG   = 2'h2
  } sfd_owner_t;
endpackage

// file: verification/sfd_flash_model.sv
// behavioural serial nor flash with an image directory at address zero
`timescale 1ns/1ns
`default_nettype none
module sfd_flash_model
  import sfd_pkg::*;
(
  // serial lines
  input  wire logic        spiSck,
  input  wire logic        spiCs_n,
  input  wire logic        spiMosi,
  output logic             spiMiso,
  // contents and observation
  input  wire logic        sfdpOk,
  input  wire logic [31:0] slot1,
  output logic [7:0]       lastCmd
);
  int          cnt;
  int          na;
  logic [7:0]  cmd;
  logic [31:0] adr;
  logic [7:0]  dat;
  // slot0 points just past the directory, slot1 comes from the bench
  function automatic logic [7:0] rd(input logic [31:0] a);
    if (cmd == CMD_DISCOVERY)
      return sfdpOk ? SFDP_SIG_WORD[8*a[1:0] +: 8] : 8'hff;
    if (a < 4)
      return DIR_SIZE_BYTES[8*a[1:0] +: 8];
    if (a < 8)
      return slot1[8*a[1:0] +: 8];
    return 8'hff;
  endfunction
  initial begin
    cnt = 0;
    na = 24;
    spiMiso = 1'b0;
    lastCmd = 8'h00;
  end
  always @(negedge spiCs_n)
    cnt = 0;
  // a released line shows the inverse, never a held copy
  always @(posedge spiCs_n)
    spiMiso = ~spiMiso;
  always @(posedge spiSck) begin
    if (!spiCs_n) begin
      if (cnt < 8)
        cmd = {cmd[6:0], spiMosi};
      else if (cnt < 8 + na)
        adr = {adr[30:0], spiMosi};
      cnt++;
      if (cnt == 8) begin
        lastCmd = cmd;
        adr = 32'h0;
        // the loader never switches the flash to 4-byte mode
        na = 24;
      end
    end
  end
  always @(negedge spiSck) begin
    if (!spiCs_n && cnt >= 16 + na) begin
      dat = rd(adr + (cnt - 16 - na) / 8);
      spiMiso = dat[7 - (cnt - 16 - na) % 8];
    end
  end
endmodule
`default_nettype wire

// file: verification/sfd_loader_asserts.sv
// port assertions for the spi flash directory loader
`timescale 1ns/1ns
`default_nettype none
module sfd_loader_asserts
  import sfd_pkg::*;
(
  // system and pins
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  jtagInstr,
  input wire logic        jtagSck,
  input wire logic        spiPortEn,
  input wire logic        spiMasterMode,
  input wire logic        spiSck,
  input wire logic        spiCs_n,
  input wire logic        spiOe,
  input wire logic        fabCs_n,
  input wire logic        fabOwns,
  // control and status
  input wire logic        iapReq,
  input wire logic        addr4Byte,
  input wire logic        recoverySel,
  input wire logic        autoUpdateSel,
  input wire logic        bootStart,
  input wire logic [31:0] imageAddr,
  input wire logic [7:0]  statusCode,
  input wire logic        statusValid,
  input wire logic        zeroCertReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // windows allow for the two-flop synchronisers
  sequence portOff; !spiPortEn [*4]; endsequence
  sequence jtagHeld; (jtagInstr == JTAG_PASS_INSTR && spiPortEn) [*8]; endsequence
  sequence iapNoMaster; (iapReq && !spiMasterMode && spiPortEn) [*4]; endsequence
  port_off_tri_a: assert property (portOff |-> !spiOe)
    else $error("spi port driven while disabled");
  jtag_drive_a: assert property (jtagHeld |-> spiOe && spiSck == jtagSck)
    else $error("jtag pass-through not driving sck");
  iap_refuse_a: assert property (iapNoMaster |-> ##[0:6] statusValid && statusCode == 8'h15)
    else $error("reprogram request not refused");
  boot_choice_a: assert property (bootStart |-> recoverySel != autoUpdateSel)
    else $error("boot selection ambiguous");
  image_above_a: assert property (bootStart |-> imageAddr >= DIR_SIZE_BYTES)
    else $error("image inside directory");
  addr3_limit_a: assert property (bootStart && !addr4Byte |-> imageAddr <= LIMIT_3BYTE)
    else $error("image beyond 3-byte range");
  fab_pass_a: assert property (fabOwns && spiOe && $stable(fabCs_n) |-> spiCs_n == fabCs_n)
    else $error("fabric select not passed");
  cert_sticky_a: assert property (zeroCertReady |=> zeroCertReady)
    else $error("certificate flag dropped");
endmodule
bind sfd_loader sfd_loader_asserts i_sfd_loader_asserts (.*);
`default_nettype wire

// file: verification/sfd_loader_tb_top.sv
// self-checking bench for the spi flash directory loader
`timescale 1ns/1ns
`default_nettype none
module sfd_loader_tb_top
  import sfd_pkg::*;
;
  logic        clk, rst_n, clkEn, jtagClk, jtagRst_n, jtagSck, jtagCs_n, jtagMosi;
  logic        spiPortEn, spiMasterMode, spiMiso, spiSck, spiCs_n, spiMosi, spiOe;
  logic        fabSck, fabCs_n, fabMosi, fabMiso, fabOwns, powerUp, brownout;
  logic        serviceReq, iapReq, zeroizeDone, addr4Byte, recoverySel, autoUpdateSel;
  logic        bootStart, statusValid, zeroCertReady, sfdpOk, seen;
  logic [7:0]  jtagInstr, statusCode, lastCmd, code;
  logic [31:0] imageAddr, slot1;
  int          err_count, checks;
  sfd_loader i_sfd_loader (.*);
  sfd_flash_model i_sfd_flash_model (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    jtagClk = 1'b0;
    forever begin
      #7 jtagClk = 1'b1;
      #8 jtagClk = 1'b0;
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_boot(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if (bootStart === 1'b1) break;
    end
    chk("bootStart", 1, bootStart);
    if (bootStart !== 1'b1) close_out();
  endtask
  // jtag reset rides along; the sync window spans many jtag edges
  task automatic do_reset();
    @(posedge clk);
    // only called between loads, never while one runs
    rst_n <= 1'b0;
    jtagRst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    jtagRst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_recover();
    sfdpOk = 1'b1;
    slot1 = 32'hffffffff;
    do_reset();
    powerUp <= 1'b1;
    @(posedge clk);
    powerUp <= 1'b0;
    wait_boot(5000);
    chk("recoverySel", 1, recoverySel);
    chk("addr4Byte", 1, addr4Byte);
    chk("imageAddr", 32'h400, imageAddr);
    repeat (4) @(posedge clk);
    fabCs_n <= 1'b0;
    fabSck <= 1'b1;
    repeat (3) @(negedge clk);
    chk("fabOwns", 1, fabOwns);
    chk("spiCs_n", 0, spiCs_n);
    chk("spiSck", 1, spiSck);
    chk("fabMiso", spiMiso, fabMiso);
    @(posedge clk);
    fabCs_n <= 1'b1;
    fabSck <= 1'b0;
    $display("t_recover done");
  endtask
  // top byte of slot1 must be ignored with 3-byte addresses
  task automatic t_update();
    sfdpOk = 1'b0;
    slot1 = 32'h5aa00000;
    do_reset();
    brownout <= 1'b1;
    @(posedge clk);
    brownout <= 1'b0;
    wait_boot(5000);
    chk("autoUpdateSel", 1, autoUpdateSel);
    chk("addr4Byte", 0, addr4Byte);
    chk("imageAddr", 32'h00a00000, imageAddr);
    chk("lastCmd", 8'h0b, lastCmd);
    // a service request takes the port back from the fabric
    @(posedge clk);
    serviceReq <= 1'b1;
    @(posedge clk);
    serviceReq <= 1'b0;
    @(negedge clk);
    chk("fabOwns", 0, fabOwns);
    $display("t_update done");
  endtask
  task automatic t_refuse();
    spiMasterMode <= 1'b0;
    do_reset();
    iapReq <= 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (statusValid === 1'b1) begin
        seen = 1'b1;
        code = statusCode;
      end
      @(posedge clk);
      if (i == 3) iapReq <= 1'b0;
    end
    chk("statusValid", 1, seen);
    chk("statusCode", 8'd21, code);
    spiMasterMode <= 1'b1;
    $display("t_refuse done");
  endtask
  task automatic t_port_off();
    do_reset();
    powerUp <= 1'b1;
    @(posedge clk);
    powerUp <= 1'b0;
    repeat (20) @(posedge clk);
    spiPortEn <= 1'b0;
    repeat (6) @(negedge clk);
    chk("spiOe", 0, spiOe);
    chk("spiCs_n", 1, spiCs_n);
    @(posedge clk);
    spiPortEn <= 1'b1;
    $display("t_port_off done");
  endtask
  task automatic t_jtag();
    do_reset();
    @(negedge clk);
    chk("spiCs_n", 1, spiCs_n);
    @(posedge jtagClk);
    jtagInstr <= JTAG_PASS_INSTR;
    jtagSck <= 1'b1;
    jtagCs_n <= 1'b0;
    repeat (10) @(negedge clk);
    chk("spiSck", 1, spiSck);
    chk("spiCs_n", 0, spiCs_n);
    @(posedge jtagClk);
    jtagInstr <= 8'h00;
    jtagSck <= 1'b0;
    jtagCs_n <= 1'b1;
    @(posedge clk);
    zeroizeDone <= 1'b1;
    @(posedge clk);
    zeroizeDone <= 1'b0;
    repeat (3) @(negedge clk);
    chk("zeroCertReady", 1, zeroCertReady);
    $display("t_jtag done");
  endtask
  initial begin
    err_count = 0;
    checks = 0;
    {rst_n, jtagRst_n, jtagSck, jtagMosi, fabSck, fabMosi, powerUp} = '0;
    {brownout, serviceReq, iapReq, zeroizeDone, sfdpOk, seen} = '0;
    {clkEn, jtagCs_n, fabCs_n, spiPortEn, spiMasterMode} = '1;
    jtagInstr = 8'h00;
    slot1 = 32'hffffffff;
    code = 8'h00;
    t_recover();
    t_update();
    t_refuse();
    t_port_off();
    t_jtag();
    close_out();
  end
endmodule
`default_nettype wire
